//--- logic/dci_core.sv
// debug command interpreter: decodes host byte frames and runs debugger commands
// Summary of operation
// - revision command returns 16-bit version, major byte then minor byte
// - status command returns the 8-bit status register as one byte
// - 16-bit runtime counter counts idle clocks outside debug from zero, saturates at maximum
// - memory, register and crc commands reuse the counter as index
// - counter read returns high byte then low byte
// - control write takes exactly one data byte into the control register
// - under readout protection a control write cannot clear the debug bit
// - control read returns the control register as one byte
// - pc write takes two bytes high first, dropped outside debug or protected
// - pc read returns pc high then low, all ones when gated
// - register write header: code, address high nibble, address low, size, data
// - register write dropped outside debug; protected allows flash regs, mass erase
// - register read returns size bytes, all ones outside debug or protected
// - program write drops data if flash locked, outside debug, or protected
// - program read returns size bytes, all ones outside debug or protected
// - data memory write drops data outside debug or protected, zero size 65536
// - data memory read all ones only outside debug; protection does not block
// - crc command reads program memory, returns crc high first, ones outside debug
// - step runs one instruction, ignored outside debug or protected
// - stuff hands host opcode to cpu for one step, ignored when gated
// - execute passes 1-7 bytes by insn_len; gated, consumes one byte only
// - control top bit set means debug state; clearing it restarts the cpu
// - link error aborts any command and requests a break back to host
`timescale 1ns/1ps
module dci_core #(
  parameter logic [15:0] VERSION = 16'h0100, // arbitrary value
  parameter logic [16:0] PROG_BYTES = 17'h10000,
  parameter logic [11:0] FLASH_REG_BASE = 12'hff0,
  parameter logic [11:0] FLASH_REG_LAST = 12'hff7,
  parameter logic [11:0] FLASH_CMD_ADDR = 12'hff0,
  parameter logic [7:0] MASS_ERASE_CODE = 8'h5e
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic link_error,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic send_break,
  input wire logic readout_protect_option,
  input wire logic flash_unlocked,
  input wire logic cpu_halted,
  input wire logic brk_decoded,
  input wire logic reset_done,
  input wire logic [15:0] pc_value,
  input wire logic [2:0] insn_len,
  output logic debug_state_bit,
  output logic sys_reset_req,
  output logic pc_load,
  output logic [15:0] pc_wdata,
  output logic cpu_step,
  output logic cpu_stuff,
  output logic cpu_insn_valid,
  output logic cpu_insn_first,
  output logic [7:0] cpu_insn_data,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_space,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum {
    ST_IDLE, ST_HDR, ST_DISPATCH, ST_WR_WAIT, ST_WR_NEXT, ST_RD_ISSUE,
    ST_RD_NEXT, ST_MEM, ST_SEND, ST_CRC, ST_CRC_DONE, ST_EXEC_LEN, ST_EXEC_BYTE
  } dci_state_e;

  dci_state_e state, next_state, ret, next_ret;
  logic [7:0] cmd, next_cmd;
  logic [31:0] hdr, next_hdr;
  logic [2:0] left, next_left;
  logic [15:0] rtc, next_rtc;
  logic [7:0] debugger_control_register, next_ctl;
  logic [7:0] tx_q, next_tx_q;
  logic tx_two, next_tx_two;
  logic next_tx_valid, next_send_break, next_pc_load, next_step, next_stuff;
  logic next_insn_valid, next_insn_first, next_mem_req, next_mem_we;
  logic [7:0] next_tx_data, next_insn_data, next_mem_wdata;
  logic [15:0] next_pc_wdata, next_mem_addr;
  logic [1:0] next_mem_space;
  logic crc_init, crc_en;
  logic [15:0] crc_val;
  logic prot, dbg;
  logic [15:0] base_addr, xfer_size, cur_addr;
  logic last, wr_ok, rd_ok, flash_ok;
  logic [1:0] space;
  logic rep_go, rep_two;
  logic [15:0] rep_val;
  logic [7:0] debugger_status_register;

  dci_crc u_crc (
    .clk(clk),
    .rst(rst),
    .init(crc_init),
    .en(crc_en),
    .data(mem_rdata),
    .crc(crc_val)
  );

  assign prot = readout_protect_option;
  assign dbg = debugger_control_register[dci_pkg::CTL_DEBUG_BIT];
  assign debug_state_bit = debugger_control_register[dci_pkg::CTL_DEBUG_BIT];
  assign sys_reset_req = debugger_control_register[dci_pkg::CTL_RST_BIT];
  // bit 5 low means the protection option is in force
  assign debugger_status_register = {dbg, cpu_halted, ~prot, 5'h00};

  // ****************************************************************
  // transfer header decode and gating
  // ****************************************************************
  always_comb begin
    base_addr = hdr[31:16];
    xfer_size = hdr[15:0];
    space = dci_pkg::SPACE_DATA;
    if (cmd == dci_pkg::CMD_REG_WR || cmd == dci_pkg::CMD_REG_RD) begin
      base_addr = {4'h0, hdr[19:8]};
      xfer_size = (hdr[7:0] == 8'h00) ? dci_pkg::REG_SIZE_ZERO : {8'h00, hdr[7:0]};
      space = dci_pkg::SPACE_REG;
    end else if (cmd == dci_pkg::CMD_PM_WR || cmd == dci_pkg::CMD_PM_RD) begin
      space = dci_pkg::SPACE_PROG;
    end
    cur_addr = base_addr + rtc;
    // memory size zero wraps to 65536 through the 16-bit compare; register size zero is 256
    last = ((rtc + 16'h0001) == xfer_size);
    flash_ok = (cur_addr[11:0] >= FLASH_REG_BASE) && (cur_addr[11:0] <= FLASH_REG_LAST)
      && ((cur_addr[11:0] != FLASH_CMD_ADDR) || (rx_data == MASS_ERASE_CODE));
    case (cmd)
      dci_pkg::CMD_REG_WR: wr_ok = dbg && (!prot || flash_ok);
      dci_pkg::CMD_PM_WR: wr_ok = dbg && !prot && flash_unlocked;
      dci_pkg::CMD_DM_WR: wr_ok = dbg && !prot;
      default: wr_ok = 1'b0;
    endcase
    case (cmd)
      dci_pkg::CMD_DM_RD: rd_ok = dbg;
      default: rd_ok = dbg && !prot;
    endcase
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_ret = ret;
    next_cmd = cmd;
    next_hdr = hdr;
    next_left = left;
    next_rtc = rtc;
    next_ctl = debugger_control_register;
    next_tx_q = tx_q;
    next_tx_two = tx_two;
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_data = tx_data;
    next_send_break = 1'b0;
    next_pc_load = 1'b0;
    next_pc_wdata = pc_wdata;
    next_step = 1'b0;
    next_stuff = 1'b0;
    next_insn_valid = 1'b0;
    next_insn_first = cpu_insn_first;
    next_insn_data = cpu_insn_data;
    next_mem_req = mem_req && !mem_ack;
    next_mem_we = mem_we;
    next_mem_space = mem_space;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    crc_init = 1'b0;
    crc_en = 1'b0;
    rep_go = 1'b0;
    rep_two = 1'b0;
    rep_val = 16'h0000;
    // reset request bit falls when the system reset completes
    if (reset_done) begin
      next_ctl[dci_pkg::CTL_RST_BIT] = 1'b0;
    end
    // the counter runs only while idle in normal mode, and restarts on leaving debug
    if (state == ST_IDLE && !dbg && rtc != dci_pkg::RTC_MAX) begin
      next_rtc = rtc + 16'h0001;
    end
    case (state)
      ST_IDLE: begin
        if (rx_valid) begin
          next_cmd = rx_data;
          next_hdr = 32'h0000_0000;
          case (rx_data)
            dci_pkg::CMD_REV: begin
              rep_go = 1'b1; rep_two = 1'b1; rep_val = VERSION;
            end
            dci_pkg::CMD_STAT: begin
              rep_go = 1'b1; rep_val = {8'h00, debugger_status_register};
            end
            dci_pkg::CMD_RTC: begin
              rep_go = 1'b1; rep_two = 1'b1; rep_val = rtc;
            end
            dci_pkg::CMD_CTL_RD: begin
              rep_go = 1'b1; rep_val = {8'h00, debugger_control_register};
            end
            dci_pkg::CMD_PC_RD: begin
              rep_go = 1'b1; rep_two = 1'b1;
              rep_val = (dbg && !prot) ? pc_value : dci_pkg::ALL_ONES16;
            end
            dci_pkg::CMD_CTL_WR: begin
              next_left = dci_pkg::HDR_CTL; next_state = ST_HDR;
            end
            dci_pkg::CMD_PC_WR: begin
              next_left = dci_pkg::HDR_PC; next_state = ST_HDR;
            end
            dci_pkg::CMD_REG_WR, dci_pkg::CMD_REG_RD: begin
              next_left = dci_pkg::HDR_REG; next_state = ST_HDR;
            end
            dci_pkg::CMD_PM_WR, dci_pkg::CMD_PM_RD, dci_pkg::CMD_DM_WR, dci_pkg::CMD_DM_RD: begin
              next_left = dci_pkg::HDR_MEM; next_state = ST_HDR;
            end
            dci_pkg::CMD_CRC: begin
              if (dbg) begin
                next_rtc = dci_pkg::RTC_RESET; crc_init = 1'b1; next_state = ST_CRC;
              end else begin
                rep_go = 1'b1; rep_two = 1'b1; rep_val = dci_pkg::ALL_ONES16;
              end
            end
            dci_pkg::CMD_STEP: next_step = dbg && !prot;
            dci_pkg::CMD_STUFF, dci_pkg::CMD_EXEC: next_state = ST_WR_WAIT;
            default: next_state = ST_IDLE;
          endcase
        end else if (brk_decoded && debugger_control_register[dci_pkg::CTL_BRKEN_BIT] && !dbg) begin
          next_ctl[dci_pkg::CTL_DEBUG_BIT] = 1'b1;
          if (debugger_control_register[dci_pkg::CTL_ACK_BIT] && !tx_valid) begin
            next_tx_valid = 1'b1;
            next_tx_data = dci_pkg::DEBUG_ACK_CHAR;
          end
        end
      end
      ST_HDR: begin
        if (rx_valid) begin
          next_hdr = {hdr[23:0], rx_data}; // high bytes arrive first
          next_left = left - 3'h1;
          if (left == 3'h1) begin
            next_rtc = dci_pkg::RTC_RESET;
            next_state = ST_DISPATCH;
          end
        end
      end
      ST_DISPATCH: begin
        next_state = ST_IDLE;
        case (cmd)
          dci_pkg::CMD_CTL_WR: begin
            next_ctl = hdr[7:0] & dci_pkg::CTL_WMASK;
            if (prot) begin
              next_ctl[dci_pkg::CTL_DEBUG_BIT] = hdr[dci_pkg::CTL_DEBUG_BIT] | dbg;
            end
            if (reset_done) begin
              next_ctl[dci_pkg::CTL_RST_BIT] = 1'b0;
            end
          end
          dci_pkg::CMD_PC_WR: begin
            next_pc_load = dbg && !prot;
            next_pc_wdata = hdr[15:0];
          end
          dci_pkg::CMD_REG_RD, dci_pkg::CMD_PM_RD, dci_pkg::CMD_DM_RD: next_state = ST_RD_ISSUE;
          default: next_state = ST_WR_WAIT;
        endcase
      end
      ST_WR_WAIT: begin
        if (rx_valid) begin
          next_insn_data = rx_data;
          next_insn_first = 1'b1;
          if (cmd == dci_pkg::CMD_STUFF) begin
            next_stuff = dbg && !prot;
            next_state = ST_IDLE;
          end else if (cmd == dci_pkg::CMD_EXEC) begin
            // gated execute eats just this byte
            next_insn_valid = dbg && !prot;
            next_state = (dbg && !prot) ? ST_EXEC_LEN : ST_IDLE;
          end else if (wr_ok) begin
            next_mem_req = 1'b1; next_mem_we = 1'b1; next_mem_space = space;
            next_mem_addr = cur_addr; next_mem_wdata = rx_data;
            next_state = ST_MEM;
          end else begin
            next_state = ST_WR_NEXT; // data dropped, frame still consumed
          end
        end
      end
      ST_WR_NEXT: begin
        next_rtc = rtc + 16'h0001;
        next_state = last ? ST_IDLE : ST_WR_WAIT;
      end
      ST_RD_ISSUE: begin
        if (rd_ok) begin
          next_mem_req = 1'b1; next_mem_we = 1'b0; next_mem_space = space;
          next_mem_addr = cur_addr;
          next_state = ST_MEM;
        end else begin
          next_tx_valid = 1'b1; next_tx_data = dci_pkg::ALL_ONES8; next_tx_two = 1'b0;
          next_ret = ST_RD_NEXT; next_state = ST_SEND;
        end
      end
      ST_RD_NEXT: begin
        next_rtc = rtc + 16'h0001;
        next_state = last ? ST_IDLE : ST_RD_ISSUE;
      end
      ST_MEM: begin
        if (mem_ack) begin
          if (mem_we) begin
            next_state = ST_WR_NEXT;
          end else begin
            next_tx_valid = 1'b1; next_tx_data = mem_rdata; next_tx_two = 1'b0;
            next_ret = ST_RD_NEXT; next_state = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (tx_valid && tx_ready) begin
          if (tx_two) begin
            next_tx_valid = 1'b1; next_tx_data = tx_q; next_tx_two = 1'b0;
          end else begin
            next_state = ret;
          end
        end
      end
      ST_CRC: begin
        if (!mem_req) begin
          next_mem_req = 1'b1; next_mem_we = 1'b0; next_mem_space = dci_pkg::SPACE_PROG;
          next_mem_addr = rtc;
        end else if (mem_ack) begin
          crc_en = 1'b1;
          next_rtc = rtc + 16'h0001;
          if (({1'b0, rtc} + 17'h00001) == PROG_BYTES) begin
            next_state = ST_CRC_DONE;
          end
        end
      end
      ST_CRC_DONE: begin
        rep_go = 1'b1; rep_two = 1'b1; rep_val = crc_val;
      end
      ST_EXEC_LEN: begin
        next_insn_first = 1'b0;
        next_left = insn_len - 3'h1;
        next_state = (insn_len > 3'h1) ? ST_EXEC_BYTE : ST_IDLE;
      end
      ST_EXEC_BYTE: begin
        if (rx_valid) begin
          next_insn_valid = 1'b1; next_insn_data = rx_data;
          next_left = left - 3'h1;
          if (left == 3'h1) begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // fixed replies: first byte out now, second parked
    if (rep_go) begin
      next_tx_valid = 1'b1;
      next_tx_data = rep_two ? rep_val[15:8] : rep_val[7:0];
      next_tx_q = rep_val[7:0];
      next_tx_two = rep_two;
      next_ret = ST_IDLE;
      next_state = ST_SEND;
    end
    // leaving debug restarts the runtime count from zero
    if (dbg && !next_ctl[dci_pkg::CTL_DEBUG_BIT]) begin
      next_rtc = dci_pkg::RTC_RESET;
    end
    // a link error overrides everything; control register is kept
    if (link_error) begin
      next_state = ST_IDLE;
      next_tx_valid = 1'b0;
      next_mem_req = 1'b0;
      next_step = 1'b0;
      next_stuff = 1'b0;
      next_insn_valid = 1'b0;
      next_pc_load = 1'b0;
      next_send_break = 1'b1;
    end
  end

  // register the sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      ret <= ST_IDLE;
      cmd <= 8'h00;
      hdr <= 32'h0000_0000;
      left <= 3'h0;
      rtc <= dci_pkg::RTC_RESET;
      debugger_control_register <= dci_pkg::CTL_RESET;
      tx_q <= 8'h00;
      tx_two <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      send_break <= 1'b0;
      pc_load <= 1'b0;
      pc_wdata <= 16'h0000;
      cpu_step <= 1'b0;
      cpu_stuff <= 1'b0;
      cpu_insn_valid <= 1'b0;
      cpu_insn_first <= 1'b0;
      cpu_insn_data <= 8'h00;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_space <= 2'h0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      state <= next_state;
      ret <= next_ret;
      cmd <= next_cmd;
      hdr <= next_hdr;
      left <= next_left;
      rtc <= next_rtc;
      debugger_control_register <= next_ctl;
      tx_q <= next_tx_q;
      tx_two <= next_tx_two;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      send_break <= next_send_break;
      pc_load <= next_pc_load;
      pc_wdata <= next_pc_wdata;
      cpu_step <= next_step;
      cpu_stuff <= next_stuff;
      cpu_insn_valid <= next_insn_valid;
      cpu_insn_first <= next_insn_first;
      cpu_insn_data <= next_insn_data;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_space <= next_mem_space;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end
endmodule : dci_core

//--- logic/dci_pkg.sv
// constants shared by the debug command interpreter files
package dci_pkg;
  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_REV = 8'h00;
  localparam logic [7:0] CMD_STAT = 8'h02;
  localparam logic [7:0] CMD_RTC = 8'h03;
  localparam logic [7:0] CMD_CTL_WR = 8'h04;
  localparam logic [7:0] CMD_CTL_RD = 8'h05;
  localparam logic [7:0] CMD_PC_WR = 8'h06;
  localparam logic [7:0] CMD_PC_RD = 8'h07;
  localparam logic [7:0] CMD_REG_WR = 8'h08;
  localparam logic [7:0] CMD_REG_RD = 8'h09;
  localparam logic [7:0] CMD_PM_WR = 8'h0a;
  localparam logic [7:0] CMD_PM_RD = 8'h0b;
  localparam logic [7:0] CMD_DM_WR = 8'h0c;
  localparam logic [7:0] CMD_DM_RD = 8'h0d;
  localparam logic [7:0] CMD_CRC = 8'h0e;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_STUFF = 8'h11;
  localparam logic [7:0] CMD_EXEC = 8'h12;

  // ****************************************************************
  // header lengths in bytes after the command code
  // ****************************************************************
  localparam logic [2:0] HDR_CTL = 3'h1;
  localparam logic [2:0] HDR_PC = 3'h2;
  localparam logic [2:0] HDR_REG = 3'h3;
  localparam logic [2:0] HDR_MEM = 3'h4;

  // ****************************************************************
  // control and status register layout
  // ****************************************************************
  localparam int CTL_DEBUG_BIT = 7;
  localparam int CTL_BRKEN_BIT = 6;
  localparam int CTL_ACK_BIT = 5;
  localparam int CTL_RST_BIT = 0;
  localparam logic [7:0] CTL_WMASK = 8'he1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] RTC_RESET = 16'h0000;
  localparam logic [15:0] RTC_MAX = 16'hffff;
  localparam logic [7:0] ALL_ONES8 = 8'hff;
  localparam logic [15:0] ALL_ONES16 = 16'hffff;
  localparam logic [7:0] DEBUG_ACK_CHAR = 8'hff;
  localparam logic [15:0] REG_SIZE_ZERO = 16'h0100;

  // ****************************************************************
  // crc-ccitt
  // ****************************************************************
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  // memory spaces reached by the transfer port
  typedef enum logic [1:0] {
    SPACE_REG,
    SPACE_PROG,
    SPACE_DATA
  } dci_space_e;
endpackage : dci_pkg

//--- logic/dci_crc.sv
// byte-wide crc-ccitt accumulator
`timescale 1ns/1ps
module dci_crc (
  input wire logic clk,
  input wire logic rst,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  logic [15:0] next_crc;

  // msb-first update, eight polynomial steps per byte
  always_comb begin
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ dci_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    next_crc = crc;
    if (init) begin
      next_crc = dci_pkg::CRC_INIT;
    end else if (en) begin
      next_crc = c;
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (rst) begin
      crc <= dci_pkg::CRC_INIT;
    end else begin
      crc <= next_crc;
    end
  end
endmodule : dci_crc

//--- sim/dci_chk.sv
// port checker for the debug command interpreter
`timescale 1ns/1ps
module dci_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_error,
  input wire logic send_break,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic debug_state_bit,
  input wire logic readout_protect_option,
  input wire logic cpu_step,
  input wire logic pc_load,
  input wire logic cpu_stuff,
  input wire logic cpu_insn_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************************************************************
  // handshakes: a pending request must not move until answered or aborted by link error
  // ****************************************************************
  sequence s_tx_wait;
    tx_valid && !tx_ready && !link_error;
  endsequence
  sequence s_mem_wait;
    mem_req && !mem_ack && !link_error;
  endsequence
  a_tx_holds: assert property (s_tx_wait |=> tx_valid && $stable(tx_data))
    else $error("reply byte moved before acceptance");
  a_mem_holds: assert property (s_mem_wait |=> mem_req && $stable(mem_addr))
    else $error("memory request moved before ack");
  a_error_aborts: assert property (link_error |=> send_break && !tx_valid && !mem_req)
    else $error("link error did not abort");
  // ****************************************************************
  // gating by debug state and protection
  // ****************************************************************
  a_prot_keeps_debug: assert property ($past(readout_protect_option) |-> !$fell(debug_state_bit))
    else $error("debug bit cleared under protection");
  a_step_gated: assert property (cpu_step |-> $past(debug_state_bit) && !readout_protect_option)
    else $error("step while gated");
  a_pc_gated: assert property (pc_load |-> debug_state_bit && !readout_protect_option)
    else $error("pc load while gated");
  a_stuff_gated: assert property (cpu_stuff |-> debug_state_bit && !readout_protect_option)
    else $error("stuff while gated");
  a_exec_gated: assert property (cpu_insn_valid |-> debug_state_bit && !readout_protect_option)
    else $error("exec byte while gated");
  a_write_gated: assert property (mem_req && mem_we |-> debug_state_bit)
    else $error("memory write outside debug");
endmodule : dci_chk

//--- sim/dci_host.sv
// host model of the debug link: sends command bytes, takes replies
`timescale 1ns/1ps
module dci_host (
  input wire logic clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic want = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // replies are taken only while recv waits, so none slips past during a send;
  // a slow host accepts every other cycle so replies must wait
  always @(negedge clk) begin
    tx_ready <= want && (slow ? ~tx_ready : 1'b1);
  end
  // one byte per frame, then a gap; released line shows the inverse
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(negedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    repeat (6) @(negedge clk);
  endtask : send
  // bounded wait for one accepted reply byte
  task automatic recv(output logic [7:0] b);
    int n;
    b = 8'hxx;
    want = 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        b = tx_data;
        break;
      end
    end
    want = 1'b0;
    @(negedge clk);
  endtask : recv
endmodule : dci_host

//--- sim/dci_tb_top.sv
// testbench for the debug command interpreter
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("unexpected %0t: %h not %h", $time, a, e); end end
module dci_tb_top;
  localparam logic [15:0] VER = 16'h0123; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_error = 1'b0;
  logic readout_protect_option = 1'b0;
  logic slow = 1'b0;
  logic mem_ack = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic [15:0] pc_value = 16'h0000;
  logic flash_unlocked = 1'b1;
  logic cpu_halted = 1'b0;
  logic brk_decoded = 1'b0;
  logic reset_done = 1'b0;
  logic [2:0] insn_len = 3'h1;
  logic rx_valid, tx_ready, tx_valid, send_break, debug_state_bit, sys_reset_req, pc_load;
  logic cpu_step, cpu_stuff, cpu_insn_valid, cpu_insn_first, mem_req, mem_we;
  logic [7:0] rx_data, tx_data, cpu_insn_data, mem_wdata, b0, b1, last_wd;
  logic [1:0] mem_space;
  logic [15:0] pc_wdata, mem_addr, r;
  int error_cnt = 0;
  int check_count = 0;
  int n_pulse = 0;
  int n_brk = 0;
  always #5 clk = ~clk;
  dci_core #(.VERSION(VER), .PROG_BYTES(17'h2)) u_dut (.*);
  dci_host u_host (.*);
  // memory answers one cycle after a request; data depends on address
  always @(negedge clk) begin
    mem_ack <= mem_req & ~mem_ack;
    mem_rdata <= mem_addr[7:0] ^ 8'h5a;
    if (mem_req && mem_we) last_wd <= mem_wdata;
  end
  // count cpu and break pulses, checked against the commands sent
  always @(posedge clk) begin
    if (cpu_step || cpu_stuff || cpu_insn_valid) n_pulse++;
    if (send_break) n_brk++;
  end
  // ****************************************************************
  // shared steps
  // ****************************************************************
  task automatic hdr(input logic [7:0] c, input logic [15:0] a, input logic [15:0] s);
    u_host.send(c);
    u_host.send(a[15:8]);
    u_host.send(a[7:0]);
    u_host.send(s[15:8]);
    u_host.send(s[7:0]);
  endtask : hdr
  task automatic get2();
    u_host.recv(b0);
    u_host.recv(b1);
  endtask : get2
  task automatic ctl_rd();
    u_host.send(8'h05);
    u_host.recv(b0);
  endtask : ctl_rd
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_rev_ctl();
    u_host.send(8'h00);
    get2();
    `CHK({b0, b1}, VER)
    // breakpoints and acknowledge on, reset request set; bits 4..1 read zero
    u_host.send(8'h04);
    u_host.send(8'h7f);
    `CHK(sys_reset_req, 1'b1)
    reset_done = 1'b1;
    @(negedge clk);
    reset_done = 1'b0;
    brk_decoded = 1'b1;
    @(negedge clk);
    brk_decoded = 1'b0;
    u_host.recv(b0);
    `CHK(b0, 8'hff)
    `CHK(debug_state_bit, 1'b1)
    ctl_rd();
    `CHK(b0, 8'he0)
    cpu_halted = 1'b1;
    u_host.send(8'h02);
    u_host.recv(b0);
    `CHK(b0, 8'he0)
    u_host.send(8'h03);
    get2();
    r = {b0, b1};
    u_host.send(8'h03);
    get2();
    `CHK({b0, b1}, r)
    $display("t_rev_ctl done");
  endtask : t_rev_ctl
  task automatic t_pc_mem();
    pc_value = 16'hbeef;
    u_host.send(8'h06);
    u_host.send(8'h12);
    u_host.send(8'h34);
    `CHK(pc_wdata, 16'h1234)
    u_host.send(8'h07);
    get2();
    `CHK({b0, b1}, 16'hbeef)
    hdr(8'h08, 16'h0010, 16'h0155);
    `CHK(last_wd, 8'h55)
    flash_unlocked = 1'b0;
    hdr(8'h0a, 16'h0030, 16'h0001);
    u_host.send(8'h66);
    `CHK(last_wd, 8'h55)
    hdr(8'h0d, 16'h0020, 16'h0001);
    u_host.recv(b0);
    `CHK(b0, 8'h7a)
    $display("t_pc_mem done");
  endtask : t_pc_mem
  task automatic t_insn();
    u_host.send(8'h10);
    u_host.send(8'h11);
    u_host.send(8'hab);
    insn_len = 3'h3;
    u_host.send(8'h12);
    u_host.send(8'hc3);
    u_host.send(8'h01);
    u_host.send(8'h02);
    `CHK(n_pulse, 5)
    `CHK(cpu_insn_data, 8'h02)
    u_host.send(8'h0f);
    u_host.send(8'h01);
    ctl_rd();
    `CHK(b0, 8'he0)
    // crc-ccitt over the two modelled program bytes 5a 5b
    u_host.send(8'h0e);
    get2();
    `CHK({b0, b1}, 16'h17e5)
    $display("t_insn done");
  endtask : t_insn
  task automatic t_prot();
    readout_protect_option = 1'b1;
    slow = 1'b1;
    u_host.send(8'h04);
    u_host.send(8'h00);
    ctl_rd();
    `CHK(b0, 8'h80)
    u_host.send(8'h07);
    get2();
    `CHK({b0, b1}, 16'hffff)
    hdr(8'h0b, 16'h0020, 16'h0001);
    u_host.recv(b0);
    `CHK(b0, 8'hff)
    hdr(8'h0d, 16'h0020, 16'h0001);
    u_host.recv(b0);
    `CHK(b0, 8'h7a)
    u_host.send(8'h12);
    u_host.send(8'h12);
    ctl_rd();
    `CHK(b0, 8'h80)
    `CHK(n_pulse, 5)
    hdr(8'h08, 16'h0ff3, 16'h0177);
    `CHK(last_wd, 8'h77)
    u_host.send(8'h04);
    link_error = 1'b1;
    @(negedge clk);
    link_error = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(n_brk, 1)
    ctl_rd();
    `CHK(b0, 8'h80)
    $display("t_prot done");
  endtask : t_prot
  // ****************************************************************
  // verdict
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // main sequence; stimulus changes on falling edges
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_rev_ctl();
    t_pc_mem();
    t_insn();
    t_prot();
    print_verdict();
  end
  // the whole run needs several hundred cycles
  initial begin
    #300000;
    error_cnt++;
    print_verdict();
  end
endmodule : dci_tb_top
bind dci_core dci_chk u_chk (.*);
